/* File: design/trip_irq_ctrl.sv */
// interrupt flags, output events, input events and recoverable trips
// assumes counter status pulses and software strobes synchronous to clk
//
// Notes on behaviour
// - every counter status source and trip unit owns a sticky flag; counter input events own none
// - enable set/clear by writing ones only
// - request while flag and enable both set
// - one shared request, software reads flags
// - flags for wrap, trigger, tick, trips, matches
// - request raised regardless of counter activity
// - output events gated by event_control bits
// - channel event captures or raises fault
// - counter input retriggers, steers, or stops
// - peak mode stores only new maxima
// - local minimum mode flags each minimum
// - local maximum and extremum mode flagging
// - trip capture channel selects target slot
// - halt field picks trip halt action
// - restart bit enables restart when the trip clears, except with halt field HALT_PERM
// - blanking field picks blanking start point
`timescale 1ns/1ns
`default_nettype none
module trip_irq_ctrl #(
  parameter int BLANK_CYC = trip_pkg::BLANK_CYC
) (
  // clock and reset
  input  wire logic                                          clk,
  input  wire logic                                          resetn,
  // counter status
  input  wire logic [trip_pkg::CNT_W-1:0]                    count,
  input  wire logic                                          wrap_event,
  input  wire logic                                          retrigger_event,
  input  wire logic                                          count_tick_event,
  input  wire logic [trip_pkg::NUM_CH-1:0]                   channel_match,
  input  wire logic                                          debug_halt_state,
  // input events and trips
  input  wire logic [trip_pkg::NUM_CH-1:0]                   channel_event,
  input  wire logic                                          counter_input_event,
  input  wire logic [trip_pkg::NUM_REC-1:0]                  recoverable_trip_n,
  // configuration
  input  wire logic [trip_pkg::EO_W-1:0]                     event_control,
  input  wire logic [trip_pkg::NUM_CH-1:0][1:0]              channel_action,
  input  wire logic [1:0]                                    counter_input_action,
  input  wire logic [trip_pkg::NUM_REC-1:0][trip_pkg::CFG_W-1:0] trip_config,
  input  wire logic                                          sw_halt_release,
  // software strobes
  input  wire logic [trip_pkg::FLAG_W-1:0]                   irq_enable_set,
  input  wire logic [trip_pkg::FLAG_W-1:0]                   irq_enable_clear,
  input  wire logic [trip_pkg::FLAG_W-1:0]                   irq_flag_clear,
  // status and request
  output logic      [trip_pkg::FLAG_W-1:0]                   irq_flags,
  output logic      [trip_pkg::FLAG_W-1:0]                   irq_enable,
  output logic                                               irq_request,
  // output events
  output logic      [trip_pkg::EO_W-1:0]                     event_out,
  // capture slots and counter control
  output logic      [trip_pkg::NUM_CH-1:0][trip_pkg::CNT_W-1:0] capture_slot,
  output logic                                               counter_restart,
  output logic                                               count_down,
  output logic                                               counter_stop,
  output logic                                               counter_halt
);
  localparam int NCH = trip_pkg::NUM_CH;
  localparam int NREC = trip_pkg::NUM_REC;
  localparam int FW = trip_pkg::FLAG_W;
  localparam int CW = trip_pkg::CNT_W;

  typedef struct packed {
    logic [FW-1:0]                  flags;
    logic [FW-1:0]                  en;
    logic                           irq;
    logic [trip_pkg::EO_W-1:0]      ev;
    logic [NCH-1:0][CW-1:0]         slot;
    logic                           dbg_prev;
    logic                           cie_prev;
    logic                           perm_hold;
    logic                           restart;
    logic                           down;
    logic                           stop;
    logic                           halt;
  } ctrl_state_t;

  ctrl_state_t             st_q;
  ctrl_state_t             st_d;
  logic [1:0]              rst_sync_q;
  logic                    rst_n;
  logic [NREC-1:0]         trip_in;
  logic [NREC-1:0][CW-1:0] sel_val;
  trip_pkg::trip_out_t     tu [NREC];
  logic [FW-1:0]           set;
  logic                    perm;
  logic [1:0]              sel;

  // ==========================================================
  // reset release
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // trip inputs and units
  always_comb
  begin
    trip_in = recoverable_trip_n;
    for (int i = 0; i < NCH; i++)
    begin
      if (channel_event[i] && channel_action[i] == trip_pkg::CH_REC)
        trip_in[i % NREC] = 1'b1;
    end
  end

  for (genvar k = 0; k < NREC; k++)
  begin : g_trip
    assign sel_val[k] = st_q.slot[trip_config[k][trip_pkg::TRIP_CAPTURE_CHANNEL_HI:trip_pkg::TRIP_CAPTURE_CHANNEL_LO]];
    trip_unit #(
      .BLANK_CYC(BLANK_CYC)
    ) u_trip (
      .clk             (clk),
      .rst_n           (rst_n),
      .fault_in        (trip_in[k]),
      .cfg             (trip_config[k]),
      .count           (count),
      .slot_val        (sel_val[k]),
      .wrap_event      (wrap_event),
      .retrigger_event (retrigger_event),
      .match_any       (|channel_match),
      .sw_halt_release (sw_halt_release),
      .out             (tu[k])
    );
  end

  // ==========================================================
  // next state
  always_comb
  begin
    st_d         = st_q;
    set          = '0;
    perm         = 1'b0;
    sel          = 2'h0;
    st_d.restart = 1'b0;
    st_d.stop    = 1'b0;
    set[trip_pkg::F_WRAP]   = wrap_event;
    set[trip_pkg::F_RETRIG] = retrigger_event;
    set[trip_pkg::F_TICK]   = count_tick_event;
    set[trip_pkg::F_DBG]    = debug_halt_state && !st_q.dbg_prev;
    st_d.dbg_prev           = debug_halt_state;
    for (int i = 0; i < NCH; i++)
    begin
      set[trip_pkg::F_MATCH0 + i] = channel_match[i];
      if (channel_event[i])
      begin
        unique case (channel_action[i])
          trip_pkg::CH_CAPTURE:
          begin
            if (st_q.flags[trip_pkg::F_MATCH0 + i])
              set[trip_pkg::F_CAPOVF] = 1'b1;
            else
            begin
              st_d.slot[i] = count;
              set[trip_pkg::F_MATCH0 + i] = 1'b1;
            end
          end
          trip_pkg::CH_PERM: perm = 1'b1;
          default: ;
        endcase
      end
    end
    for (int k = 0; k < NREC; k++)
    begin
      sel = trip_config[k][trip_pkg::TRIP_CAPTURE_CHANNEL_HI:trip_pkg::TRIP_CAPTURE_CHANNEL_LO];
      if (tu[k].cap)
        st_d.slot[sel] = tu[k].val;
      set[trip_pkg::F_REC0 + k] = tu[k].flag;
      if (tu[k].nonrec)
        perm = 1'b1;
      if (tu[k].restart)
        st_d.restart = 1'b1;
    end
    set[trip_pkg::F_PERM] = perm;
    st_d.perm_hold = (st_q.perm_hold && !irq_flag_clear[trip_pkg::F_PERM]) || perm;
    st_d.cie_prev = counter_input_event;
    unique case (counter_input_action)
      trip_pkg::CIE_RETRIG:
        if (counter_input_event && !st_q.cie_prev)
          st_d.restart = 1'b1;
      trip_pkg::CIE_DIR: st_d.down = counter_input_event;
      trip_pkg::CIE_STOP: st_d.stop = counter_input_event && !st_q.cie_prev;
      default: ;
    endcase
    st_d.halt = st_d.perm_hold;
    for (int k = 0; k < NREC; k++)
    begin
      if (tu[k].halt)
        st_d.halt = 1'b1;
    end
    st_d.ev[trip_pkg::EO_WRAP]   = wrap_event && event_control[trip_pkg::EO_WRAP];
    st_d.ev[trip_pkg::EO_RETRIG] = retrigger_event && event_control[trip_pkg::EO_RETRIG];
    st_d.ev[trip_pkg::EO_TICK]   = count_tick_event && event_control[trip_pkg::EO_TICK];
    for (int i = 0; i < NCH; i++)
    begin
      st_d.ev[trip_pkg::EO_MATCH0 + i] =
        channel_match[i] && event_control[trip_pkg::EO_MATCH0 + i];
    end
    st_d.flags = (st_q.flags & ~irq_flag_clear) | set;
    st_d.en = (st_q.en & ~irq_enable_clear) | irq_enable_set;
    st_d.irq = |(st_d.flags & st_d.en);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ==========================================================
  // outputs
  assign irq_flags       = st_q.flags;
  assign irq_enable      = st_q.en;
  assign irq_request     = st_q.irq;
  assign event_out       = st_q.ev;
  assign capture_slot    = st_q.slot;
  assign counter_restart = st_q.restart;
  assign count_down      = st_q.down;
  assign counter_stop    = st_q.stop;
  assign counter_halt    = st_q.halt;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_flag_sets: assert property (
    wrap_event |=> irq_flags[trip_pkg::F_WRAP])
    else $error("wrap flag not set by its source");

  a_flag_holds: assert property (
    (irq_flags[trip_pkg::F_TICK] && !irq_flag_clear[trip_pkg::F_TICK])
    |=> irq_flags[trip_pkg::F_TICK])
    else $error("tick flag lost without a clear");

  a_flag_clears: assert property (
    (irq_flag_clear[trip_pkg::F_TICK] && !count_tick_event) |=> !irq_flags[trip_pkg::F_TICK])
    else $error("tick flag not cleared by a one");

  a_enable_zero: assert property (
    (!irq_enable_set[0] && !irq_enable_clear[0]) |=> $stable(irq_enable[0]))
    else $error("enable changed on a zero write");

  a_enable_set: assert property (
    (irq_enable_set[0] && !irq_enable_clear[0]) |=> irq_enable[0])
    else $error("enable not set by a one");

  a_irq_level: assert property (
    irq_request == |(irq_flags & irq_enable))
    else $error("request disagrees with flags and enables");

  a_event_gate: assert property (
    (wrap_event && !event_control[trip_pkg::EO_WRAP]) |=> !event_out[trip_pkg::EO_WRAP])
    else $error("wrap event produced while disabled");

  a_event_pass: assert property (
    (wrap_event && event_control[trip_pkg::EO_WRAP]) |=> event_out[trip_pkg::EO_WRAP])
    else $error("enabled wrap event not produced");

  a_capture_ovf: assert property (
    (channel_event[0] && channel_action[0] == trip_pkg::CH_CAPTURE
     && irq_flags[trip_pkg::F_MATCH0]) |=> irq_flags[trip_pkg::F_CAPOVF])
    else $error("capture overflow not flagged");

  sequence s_cie_rise;
    !counter_input_event ##1 counter_input_event;
  endsequence
  a_cie_retrig: assert property (
    s_cie_rise ##0 (counter_input_action == trip_pkg::CIE_RETRIG) |=> counter_restart)
    else $error("counter input did not retrigger");

  a_perm_halts: assert property (
    $rose(irq_flags[trip_pkg::F_PERM]) |-> counter_halt)
    else $error("permanent trip did not halt the counter");
endmodule
`default_nettype wire

/* File: shared/trip_pkg.sv */
// constants and carriers for the timer interrupt, event and fault control
// assumes a single 25 MHz peripheral clock and synchronous inputs
package trip_pkg;

  // ==========================================================
  // sizes and clock
  localparam int NUM_CH        = 4;
  localparam int NUM_REC       = 2;
  localparam int CNT_W         = 16;
  localparam int CLK_PERIOD_NS = 40;
  localparam int BLANK_NS      = 400;
  localparam int BLANK_CYC     = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // irq flag bit positions
  localparam int F_WRAP   = 0;
  localparam int F_RETRIG = 1;
  localparam int F_TICK   = 2;
  localparam int F_CAPOVF = 3;
  localparam int F_DBG    = 4;
  localparam int F_REC0   = 5;
  localparam int F_PERM   = F_REC0 + NUM_REC;
  localparam int F_MATCH0 = F_PERM + 1;
  localparam int FLAG_W   = F_MATCH0 + NUM_CH;

  // ==========================================================
  // event_control bit positions
  localparam int EO_WRAP   = 0;
  localparam int EO_RETRIG = 1;
  localparam int EO_TICK   = 2;
  localparam int EO_MATCH0 = 3;
  localparam int EO_W      = EO_MATCH0 + NUM_CH;

  // ==========================================================
  // trip configuration word fields
  localparam int CFG_W      = 12;
  localparam int TRIP_CAPTURE_CHANNEL_HI   = 11;
  localparam int TRIP_CAPTURE_CHANNEL_LO   = 10;
  localparam int HALT_HI    = 9;
  localparam int HALT_LO    = 8;
  localparam int RESTART_B  = 7;
  localparam int BLANK_HI   = 6;
  localparam int BLANK_LO   = 5;
  localparam int CAPMODE_HI = 2;
  localparam int CAPMODE_LO = 0;

  // ==========================================================
  // field codes
  localparam logic [2:0] CAP_PEAK   = 3'h3;
  localparam logic [2:0] CAP_LMIN   = 3'h4;
  localparam logic [2:0] CAP_LMAX   = 3'h5;
  localparam logic [2:0] CAP_EXT    = 3'h6;
  localparam logic [1:0] HALT_NONE  = 2'h0;
  localparam logic [1:0] HALT_HW    = 2'h1;
  localparam logic [1:0] HALT_SW    = 2'h2;
  localparam logic [1:0] HALT_PERM  = 2'h3;
  localparam logic [1:0] BLANK_NONE = 2'h0;
  localparam logic [1:0] BLANK_WRAP = 2'h1;
  localparam logic [1:0] BLANK_TRIG = 2'h2;
  localparam logic [1:0] BLANK_MTCH = 2'h3;
  localparam logic [1:0] CH_NONE    = 2'h0;
  localparam logic [1:0] CH_CAPTURE = 2'h1;
  localparam logic [1:0] CH_REC     = 2'h2;
  localparam logic [1:0] CH_PERM    = 2'h3;
  localparam logic [1:0] CIE_NONE   = 2'h0;
  localparam logic [1:0] CIE_RETRIG = 2'h1;
  localparam logic [1:0] CIE_DIR    = 2'h2;
  localparam logic [1:0] CIE_STOP   = 2'h3;

  // ==========================================================
  // trip unit results
  typedef struct packed {
    logic             cap;
    logic [CNT_W-1:0] val;
    logic             flag;
    logic             halt;
    logic             restart;
    logic             nonrec;
  } trip_out_t;

endpackage

/* File: design/trip_unit.sv */
// one recoverable trip input: blanking, capture mode, halt and restart
// assumes synchronous inputs and a reset already synchronised
`timescale 1ns/1ns
`default_nettype none
module trip_unit #(
  parameter int BLANK_CYC = trip_pkg::BLANK_CYC
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // trip and counter status
  input  wire logic                        fault_in,
  input  wire logic [trip_pkg::CFG_W-1:0]  cfg,
  input  wire logic [trip_pkg::CNT_W-1:0]  count,
  input  wire logic [trip_pkg::CNT_W-1:0]  slot_val,
  input  wire logic                        wrap_event,
  input  wire logic                        retrigger_event,
  input  wire logic                        match_any,
  input  wire logic                        sw_halt_release,
  // results
  output var trip_pkg::trip_out_t          out
);
  localparam int BW = $clog2(BLANK_CYC + 1);

  typedef struct packed {
    logic                      prev;
    logic [BW-1:0]             blank;
    logic                      sw_hold;
    logic                      trend_up;
    logic                      have_last;
    logic [trip_pkg::CNT_W-1:0] last_val;
    trip_pkg::trip_out_t       out;
  } unit_state_t;

  unit_state_t s_q;
  unit_state_t s_d;
  logic [2:0]  mode;
  logic [1:0]  halt;
  logic [1:0]  blank;
  logic        rise;
  logic        up;
  logic        start;

  // ==========================================================
  // next state
  always_comb
  begin
    s_d         = s_q;
    mode        = cfg[trip_pkg::CAPMODE_HI:trip_pkg::CAPMODE_LO];
    halt        = cfg[trip_pkg::HALT_HI:trip_pkg::HALT_LO];
    blank       = cfg[trip_pkg::BLANK_HI:trip_pkg::BLANK_LO];
    s_d.prev    = fault_in;
    s_d.out.cap = 1'b0;
    s_d.out.val = count;
    s_d.out.flag = 1'b0;
    rise        = fault_in && !s_q.prev && (s_q.blank == '0);
    up          = count > s_q.last_val;
    unique case (blank)
      trip_pkg::BLANK_WRAP: start = wrap_event;
      trip_pkg::BLANK_TRIG: start = retrigger_event;
      trip_pkg::BLANK_MTCH: start = match_any;
      default:              start = 1'b0;
    endcase
    if (start)
      s_d.blank = BW'(BLANK_CYC);
    else if (s_q.blank != '0)
      s_d.blank = s_q.blank - BW'(1);
    if (rise)
    begin
      unique case (mode)
        trip_pkg::CAP_PEAK:
        begin
          s_d.out.cap  = count > slot_val;
          s_d.out.flag = count > slot_val;
        end
        trip_pkg::CAP_LMIN:
        begin
          s_d.out.cap  = 1'b1;
          s_d.out.flag = s_q.have_last && !s_q.trend_up && up;
        end
        trip_pkg::CAP_LMAX:
        begin
          s_d.out.cap  = 1'b1;
          s_d.out.flag = s_q.have_last && s_q.trend_up && !up;
        end
        trip_pkg::CAP_EXT:
        begin
          s_d.out.cap  = 1'b1;
          s_d.out.flag = s_q.have_last && (s_q.trend_up != up);
        end
        default: s_d.out.flag = 1'b1;
      endcase
      if (mode >= trip_pkg::CAP_LMIN && mode <= trip_pkg::CAP_EXT)
      begin
        s_d.last_val  = count;
        s_d.trend_up  = up;
        s_d.have_last = 1'b1;
      end
    end
    s_d.sw_hold    = (s_q.sw_hold && !sw_halt_release) || (rise && halt == trip_pkg::HALT_SW);
    s_d.out.halt   = (halt == trip_pkg::HALT_HW && fault_in) || s_d.sw_hold;
    s_d.out.nonrec = rise && halt == trip_pkg::HALT_PERM;
    s_d.out.restart = cfg[trip_pkg::RESTART_B] && s_q.prev && !fault_in
                      && halt != trip_pkg::HALT_PERM;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign out = s_q.out;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_peak_no_lower: assert property (
    (rise && mode == trip_pkg::CAP_PEAK && count <= slot_val) |=> !out.cap && !out.flag)
    else $error("peak capture stored a value that was not higher");

  sequence s_blank_start;
    blank == trip_pkg::BLANK_WRAP && wrap_event;
  endsequence
  a_blank_masks: assert property (
    s_blank_start ##1 (fault_in && !s_q.prev) |=> !out.cap && !out.flag)
    else $error("trip accepted inside blanking window");
endmodule
`default_nettype wire

/* File: test/count_model.sv */
// counter model standing at the far side of the trip controller
// assumes registered restart, stop and direction outputs from the controller
`timescale 1ns/1ns
`default_nettype none
module count_model #(
  parameter logic [15:0] TOP = 16'h00FF
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        run,
  input  wire logic        restart,
  input  wire logic        stop,
  input  wire logic        down,
  // status
  output logic      [15:0] count,
  output logic             wrap_event
);
  // ==========================================================
  // counter with wrap pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count      <= 16'h0000;
      wrap_event <= 1'b0;
    end
    else
    begin
      wrap_event <= run && !stop && count == TOP;
      if (restart)
        count <= 16'h0000;
      else if (run && !stop)
        count <= (count == TOP) ? 16'h0000 : count + (down ? 16'hFFFF : 16'h0001);
    end
  end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the trip interrupt and event controller
// assumes count_model stands in for the counter
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int FW = trip_pkg::FLAG_W;
  logic                        clk = 1'b0;
  logic                        resetn = 1'b0;
  logic                        run = 1'b0;
  logic                        retrig = 1'b0, tick = 1'b0, dbg = 1'b0, cin = 1'b0;
  logic [3:0]                  match = '0, chev = '0;
  logic [6:0]                  ec = '0, r;
  logic [3:0][1:0]             cact = '0;
  logic [1:0]                  cia = '0;
  logic [1:0][11:0]            cfg = '0;
  logic [1:0]                  trip = '0;
  logic [FW-1:0]               en_set = '0, en_clr = '0, fclr = '0, en_exp, a, b, c, m;
  logic [FW-1:0]               irq_flags, irq_enable;
  logic [6:0]                  event_out;
  logic [3:0][15:0]            capture_slot;
  logic [15:0]                 count;
  logic                        wrap_event, irq_request, restart, down, stop, halt, seen;
  logic                        swr = 1'b0;
  int                          seed = 72891, error_cnt = 0, n_tests = 0, cyc = 0;

  always #20 clk = ~clk;

  count_model cm_u (.clk(clk), .rst_n(resetn), .run(run), .restart(restart), .stop(stop),
    .down(down), .count(count), .wrap_event(wrap_event));

  trip_irq_ctrl #(.BLANK_CYC(3)) dut_u (.clk(clk), .resetn(resetn), .count(count),
    .wrap_event(wrap_event), .retrigger_event(retrig), .count_tick_event(tick),
    .channel_match(match), .debug_halt_state(dbg), .channel_event(chev),
    .counter_input_event(cin), .recoverable_trip_n(trip), .event_control(ec),
    .channel_action(cact), .counter_input_action(cia), .trip_config(cfg),
    .sw_halt_release(swr), .irq_enable_set(en_set), .irq_enable_clear(en_clr),
    .irq_flag_clear(fclr), .irq_flags(irq_flags), .irq_enable(irq_enable),
    .irq_request(irq_request), .event_out(event_out), .capture_slot(capture_slot),
    .counter_restart(restart), .count_down(down), .counter_stop(stop), .counter_halt(halt));

  // ==========================================================
  // expectations and compares
  function automatic logic [FW-1:0] exp_fl(input logic [6:0] s);
    exp_fl = {s[6:3], 3'h0, s[2], 1'h0, s[1], s[0], 1'h0};
  endfunction

  task automatic chk_v(input logic [15:0] g, input logic [15:0] e, input string t);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, t, g, e);
    end
  endtask

  task automatic chk_b(input logic g, input logic e, input string t);
    chk_v({15'h0, g}, {15'h0, e}, t);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic clr_all;
    @(posedge clk) fclr <= '1;
    @(posedge clk) fclr <= '0;
  endtask

  task automatic drv_trip(input logic v);
    @(posedge clk) trip[0] <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic step(input logic d, input int n);
    @(posedge clk) {cin, run} <= {d, 1'b1};
    repeat (n) @(posedge clk);
    run <= 1'b0;
    drv_trip(1'b1);
    drv_trip(1'b0);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out;
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk_v(16'(irq_flags), 16'h0000, "reset flags");
    a = FW'($random(seed));
    b = FW'($random(seed));
    c = FW'($random(seed));
    @(posedge clk) en_set <= a;
    @(posedge clk) {en_set, en_clr} <= {{FW{1'b0}}, b};
    @(posedge clk) {en_set, en_clr} <= {c, c};
    #1 chk_v(16'(irq_enable), 16'(a & ~b), "enable clear");
    @(posedge clk) {en_set, en_clr} <= '0;
    en_exp = (a & ~b) | c;
    #1 chk_v(16'(irq_enable), 16'(en_exp), "enable set wins");
    repeat (20)
    begin
      r = 7'($random(seed));
      @(posedge clk) {match, dbg, tick, retrig, ec} <= {r, 7'($random(seed))};
      @(posedge clk) {match, dbg, tick, retrig} <= '0;
      #1 chk_v(16'(irq_flags), 16'(exp_fl(r)), "source flags");
      chk_v(16'(event_out), 16'({r[6:3], r[1:0], 1'b0} & ec), "events");
      chk_b(irq_request, |(exp_fl(r) & en_exp), "request");
      m = FW'($random(seed));
      @(posedge clk) fclr <= m;
      @(posedge clk) fclr <= '0;
      #1 chk_v(16'(irq_flags), 16'(exp_fl(r) & ~m), "flag clear");
      chk_b(irq_request, |(exp_fl(r) & ~m & en_exp), "request hold");
      clr_all;
    end
    @(posedge clk) {run, ec} <= {1'b1, 7'h01};
    for (int k = 0; k < 400 && irq_flags[trip_pkg::F_WRAP] !== 1'b1; k++)
      @(posedge clk);
    #1 chk_b(irq_flags[trip_pkg::F_WRAP], 1'b1, "wrap flag");
    chk_b(irq_request, en_exp[trip_pkg::F_WRAP], "wrap request");
    for (int ch = 0; ch < 4; ch++)
    begin
      @(posedge clk) run <= 1'b1;
      repeat (($random(seed) & 7) + 2) @(posedge clk);
      run <= 1'b0;
      cfg[0] <= {2'(ch), trip_pkg::HALT_HW, 1'b0, trip_pkg::BLANK_NONE, 2'h0, trip_pkg::CAP_PEAK};
      clr_all;
      drv_trip(1'b1);
      chk_v(capture_slot[ch], count, "peak slot");
      chk_b(irq_flags[trip_pkg::F_REC0], 1'b1, "peak flag");
      chk_b(halt, 1'b1, "hw halt");
      drv_trip(1'b0);
      chk_b(halt, 1'b0, "hw halt off");
      clr_all;
      drv_trip(1'b1);
      chk_b(irq_flags[trip_pkg::F_REC0], 1'b0, "no new peak");
      drv_trip(1'b0);
    end
    @(posedge clk) cfg[0] <= {2'h0, trip_pkg::HALT_NONE, 1'b1, trip_pkg::BLANK_NONE, 5'h00};
    clr_all;
    drv_trip(1'b1);
    chk_b(irq_flags[trip_pkg::F_REC0], 1'b1, "mode zero flag");
    drv_trip(1'b0);
    chk_v(count, 16'h0000, "restart");
    @(posedge clk) cfg[0] <= {2'h0, trip_pkg::HALT_PERM, 1'b0, trip_pkg::BLANK_NONE, 5'h00};
    clr_all;
    drv_trip(1'b1);
    drv_trip(1'b0);
    chk_b(irq_flags[trip_pkg::F_PERM], 1'b1, "permanent flag");
    chk_b(halt, 1'b1, "permanent halt");
    clr_all;
    #1 chk_b(halt, 1'b0, "permanent release");
    for (int k = 1; k < 4; k++)
    begin
      @(posedge clk) cia <= 2'(k);
      @(posedge clk) cin <= 1'b1;
      seen = 1'b0;
      repeat (3)
      begin
        @(posedge clk);
        #1 seen = seen | (k == 1 ? restart : k == 2 ? down : stop);
      end
      chk_b(seen, 1'b1, "input action");
      @(posedge clk) cin <= 1'b0;
    end
    @(posedge clk) {cact[0], chev[0]} <= {trip_pkg::CH_CAPTURE, 1'b1};
    @(posedge clk) chev[0] <= 1'b0;
    @(posedge clk) chev[0] <= 1'b1;
    @(posedge clk) chev[0] <= 1'b0;
    #1 chk_v(capture_slot[0], count, "channel capture");
    chk_b(irq_flags[trip_pkg::F_CAPOVF], 1'b1, "capture overflow");
    @(posedge clk) cfg[0] <= {2'h1, trip_pkg::HALT_SW, 1'b0, trip_pkg::BLANK_NONE, 5'h00};
    clr_all;
    drv_trip(1'b1);
    drv_trip(1'b0);
    chk_b(halt, 1'b1, "sw halt held");
    @(posedge clk) swr <= 1'b1;
    @(posedge clk) swr <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk_b(halt, 1'b0, "sw halt release");
    @(posedge clk) {cia, cfg[0]} <= {trip_pkg::CIE_DIR, 2'h2, trip_pkg::HALT_NONE, 3'h0, 2'h0,
      trip_pkg::CAP_LMIN};
    clr_all;
    step(1'b0, 20);
    step(1'b0, 5);
    step(1'b1, 4);
    chk_b(irq_flags[trip_pkg::F_REC0], 1'b0, "no minimum yet");
    step(1'b0, 4);
    chk_b(irq_flags[trip_pkg::F_REC0], 1'b1, "local minimum");
    chk_v(capture_slot[2], count, "minimum slot");
    close_out;
  end
endmodule
`default_nettype wire
